// >>> core/setce_cmd_engine.sv
// Command engine of a secure serial EEPROM on a two-wire bus
// Overview of operation
// RL1 - Commands are command, address1, address2, length; sequential read is one byte
// RL2 - A stop condition closes every command and triggers its action
// RL3 - Host polls completion by start plus command byte, repeating until acked
// RL4 - While busy the command byte is not acked; ack means done only
// RL5 - No polling needed after reads or zone selection
// RL6 - Poll after plain writes; encrypted writes are followed by checksum
// RL7 - After verify or password commands poll only with read commands
// RL8 - Ready within 5ms after user write, 20ms with anti-tearing
// RL9 - Checksum busy at most 5ms, 20ms with anti-tearing
// RL10 - Config write busy 5ms, 20ms anti-tearing; fuse write 5ms
// RL11 - Verify and password commands busy at most 10ms
// RL12 - Upper command nibble is the address; universal value always accepted
// RL13 - Low nibble of device config byte is a second accepted address
// RL14 - All bytes travel most significant bit first
// RL15 - User write length at most sixteen, eight in anti-tearing mode
// RL16 - Anti-tearing zone selection applies to every later user write
// RL17 - Host keeps each write inside one sixteen byte page
// RL18 - Crypto mode writes wait for a valid checksum, else discarded
// RL19 - Host sends the checksum as the very next command
// RL20 - Write length byte is not acked when write access is refused
// RL21 - Four write bytes then repeated start latch the read pointer
// RL22 - Sequential read sends byte at pointer, pointer advances per byte
// RL23 - Bytes continue while host acks; a not-ack ends the read
// RL24 - Pointer wraps from last byte of the zone to its first
// RL25 - Sequential read serves config memory or user zone per dummy write
// RL26 - Host bounds its polling attempts and reports a timeout
`timescale 1ns/1ps
`default_nettype none
module setce_cmd_engine #(
	parameter int BUF_DEPTH = 16,
	parameter int USER_AW = 9,
	parameter int CFG_AW = 8,
	parameter int BUSY_WR_CYC = setce_pkg::BUSY_WR_CYC,
	parameter int BUSY_AT_CYC = setce_pkg::BUSY_AT_CYC,
	parameter int BUSY_CR_CYC = setce_pkg::BUSY_CR_CYC
) (
	input wire logic I_REF_CLK,
	input wire logic I_SRST,
	input wire logic I_SCL,
	input wire logic I_SDA,
	output logic O_SDA_OUT,
	output logic O_SDA_OE,
	input wire logic [7:0] I_DEV_CONFIG_BYTE,
	input wire logic I_WRITE_ALLOWED,
	input wire logic I_CRYPTO_MODE,
	input wire logic I_CHECKSUM_VALID,
	input wire logic [7:0] I_MEM_RDATA,
	output logic [15:0] O_MEM_ADDR,
	output logic O_MEM_CFG_SEL,
	output logic O_MEM_WE,
	output logic [7:0] O_MEM_WDATA,
	output logic O_BUSY,
	output logic O_ANTI_TEAR,
	output logic O_WRITE_PENDING,
	output logic O_CRYPTO_RESET
);
	localparam int BI_W = $clog2(BUF_DEPTH);
	localparam int BW = setce_pkg::BUSY_W;
	localparam logic [15:0] USER_MASK = 16'((1 << USER_AW) - 1);
	localparam logic [15:0] CFG_MASK = 16'((1 << CFG_AW) - 1);

	setce_pkg::setce_state_t state_r;
	logic sda_s, scl_rise, scl_fall, start_c, stop_c, busy;
	logic [3:0] bitcnt_r;
	logic [7:0] shreg_r, txsh_r, cmd_r, a1_r, a2_r, device_config_byte_r;
	logic [2:0] idx_r;
	logic cmd_ok_r, tx_go_r, wr_ok_r, host_ack_r, cfg_sel_r, wact_r;
	logic [BI_W:0] dcnt_r, widx_r;
	logic [7:0] buf_r [BUF_DEPTH];
	logic [15:0] ptr_r, wbase_r, ptr_nxt, mask;
	logic busy_go_r;
	logic [BW-1:0] busy_len_r;
	logic byte_done, ack_c, addr_hit, tx_load, end_c;
	logic [7:0] len_max;
	logic [3:0] op;

	setce_twi_sync u_sync (
		.i_clk(I_REF_CLK),
		.i_srst(I_SRST),
		.i_scl(I_SCL),
		.i_sda(I_SDA),
		.o_sda(sda_s),
		.o_scl_rise(scl_rise),
		.o_scl_fall(scl_fall),
		.o_start(start_c),
		.o_stop(stop_c)
	);

	setce_busy_timer #(.W(BW)) u_busy (
		.i_clk(I_REF_CLK),
		.i_srst(I_SRST),
		.i_load(busy_go_r),
		.i_count(busy_len_r),
		.o_busy(busy)
	);

	assign O_BUSY = busy;
	assign op = cmd_r[3:0];
	assign byte_done = (state_r == setce_pkg::ST_RX) && scl_fall &&
		(bitcnt_r == 4'h8);
	assign addr_hit = (shreg_r[7:4] == setce_pkg::UNIV_ADDR) || // RL12
		(shreg_r[7:4] == device_config_byte_r[3:0]); // RL13
	assign len_max = O_ANTI_TEAR ? setce_pkg::MAX_LEN_AT :
		setce_pkg::MAX_LEN;
	assign tx_load = scl_fall && (((state_r == setce_pkg::ST_RACK) &&
		tx_go_r) || ((state_r == setce_pkg::ST_TACK) && host_ack_r));
	assign end_c = stop_c && cmd_ok_r && (idx_r == 3'h4); // RL2
	assign mask = cfg_sel_r ? CFG_MASK : USER_MASK;
	assign ptr_nxt = (ptr_r & ~mask) | ((ptr_r + 16'h0001) & mask); // RL24

	// Acknowledge decision for the byte just shifted in
	always_comb
	begin
		ack_c = 1'b1;
		if (idx_r == 3'h0)
			ack_c = addr_hit && !busy; // RL4
		else if ((idx_r == 3'h3) && (op == setce_pkg::OP_WR_USER))
			ack_c = I_WRITE_ALLOWED && (shreg_r <= len_max); // RL20 RL15
	end

	// Config byte is factory erased until the config store reports it
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_SRST)
			device_config_byte_r <= setce_pkg::CFG_FACTORY;
		else
			device_config_byte_r <= I_DEV_CONFIG_BYTE;
	end

	// Bit level engine; open drain so a one releases the line
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_SRST)
		begin
			state_r <= setce_pkg::ST_IDLE;
			bitcnt_r <= 4'h0;
			shreg_r <= 8'h00;
			txsh_r <= 8'h00;
			host_ack_r <= 1'b0;
			O_SDA_OE <= 1'b0;
			O_SDA_OUT <= 1'b0;
		end
		else if (start_c)
		begin
			state_r <= setce_pkg::ST_RX;
			bitcnt_r <= 4'h0;
			O_SDA_OE <= 1'b0;
		end
		else if (stop_c)
		begin
			state_r <= setce_pkg::ST_IDLE;
			O_SDA_OE <= 1'b0;
		end
		else
		begin
			unique case (state_r)
			setce_pkg::ST_IDLE:
				O_SDA_OE <= 1'b0;
			setce_pkg::ST_RX:
				if (scl_rise && (bitcnt_r != 4'h8))
				begin
					shreg_r <= {shreg_r[6:0], sda_s}; // RL14
					bitcnt_r <= bitcnt_r + 4'h1;
				end
				else if (byte_done)
				begin
					O_SDA_OE <= ack_c;
					state_r <= ack_c ? setce_pkg::ST_RACK : setce_pkg::ST_IDLE;
				end
			setce_pkg::ST_RACK:
				if (scl_fall)
				begin
					bitcnt_r <= 4'h0;
					if (tx_go_r)
					begin
						txsh_r <= I_MEM_RDATA; // RL22
						O_SDA_OE <= ~I_MEM_RDATA[7]; // RL14
						state_r <= setce_pkg::ST_TX;
					end
					else
					begin
						O_SDA_OE <= 1'b0;
						state_r <= setce_pkg::ST_RX;
					end
				end
			setce_pkg::ST_TX:
				if (scl_fall)
				begin
					if (bitcnt_r == 4'h7)
					begin
						O_SDA_OE <= 1'b0;
						state_r <= setce_pkg::ST_TACK;
					end
					else
					begin
						bitcnt_r <= bitcnt_r + 4'h1;
						txsh_r <= {txsh_r[6:0], 1'b0};
						O_SDA_OE <= ~txsh_r[6];
					end
				end
			setce_pkg::ST_TACK:
				if (scl_rise)
					host_ack_r <= ~sda_s;
				else if (scl_fall)
				begin
					bitcnt_r <= 4'h0;
					if (host_ack_r)
					begin
						txsh_r <= I_MEM_RDATA; // RL23
						O_SDA_OE <= ~I_MEM_RDATA[7];
						state_r <= setce_pkg::ST_TX;
					end
					else
						state_r <= setce_pkg::ST_IDLE; // RL23
				end
			default:
				state_r <= setce_pkg::ST_IDLE;
			endcase
		end
	end

	// Byte sequencing; a start aborts the command, which makes a dummy write
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_SRST)
		begin
			idx_r <= 3'h0;
			cmd_r <= 8'h00;
			a1_r <= 8'h00;
			a2_r <= 8'h00;
			cmd_ok_r <= 1'b0;
			tx_go_r <= 1'b0;
			wr_ok_r <= 1'b0;
			dcnt_r <= '0;
		end
		else if (start_c || stop_c)
		begin
			idx_r <= 3'h0;
			cmd_ok_r <= 1'b0;
			tx_go_r <= 1'b0;
		end
		else if (byte_done)
		begin
			if (idx_r != 3'h4)
				idx_r <= idx_r + 3'h1; // RL1
			if (idx_r == 3'h0)
			begin
				cmd_r <= shreg_r;
				cmd_ok_r <= ack_c;
				tx_go_r <= ack_c && (shreg_r[3:0] == setce_pkg::OP_RAND_RD);
			end
			else if (idx_r == 3'h1)
				a1_r <= shreg_r;
			else if (idx_r == 3'h2)
				a2_r <= shreg_r;
			else if (idx_r == 3'h3)
			begin
				tx_go_r <= (op == setce_pkg::OP_RD_USER) ||
					(op == setce_pkg::OP_SYS_RD);
				if (op == setce_pkg::OP_WR_USER)
				begin
					wr_ok_r <= ack_c; // RL20
					dcnt_r <= '0;
				end
			end
			else if ((op == setce_pkg::OP_WR_USER) &&
				(dcnt_r < (BI_W + 1)'(BUF_DEPTH)))
			begin
				buf_r[dcnt_r[BI_W-1:0]] <= shreg_r; // RL18
				dcnt_r <= dcnt_r + (BI_W + 1)'(1);
			end
		end
	end

	// Read pointer and space select; the refused length byte still loads it
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_SRST)
		begin
			ptr_r <= 16'h0000;
			wbase_r <= 16'h0000;
			cfg_sel_r <= 1'b0;
		end
		else if (byte_done && (idx_r == 3'h3))
		begin
			cfg_sel_r <= (op == setce_pkg::OP_SYS_WR) ||
				(op == setce_pkg::OP_SYS_RD); // RL25
			if ((op == setce_pkg::OP_SYS_WR) || (op == setce_pkg::OP_SYS_RD))
				ptr_r <= {8'h00, a2_r}; // RL21
			else
				ptr_r <= {a1_r, a2_r}; // RL21
			if (op == setce_pkg::OP_WR_USER)
				wbase_r <= {a1_r, a2_r};
		end
		else if (tx_load)
			ptr_r <= ptr_nxt; // RL22
	end

	// End-of-command actions: busy time, anti-tearing, crypto hold
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_SRST)
		begin
			busy_go_r <= 1'b0;
			busy_len_r <= '0;
			O_ANTI_TEAR <= 1'b0;
			O_WRITE_PENDING <= 1'b0;
			O_CRYPTO_RESET <= 1'b0;
			wact_r <= 1'b0;
		end
		else
		begin
			busy_go_r <= 1'b0;
			O_CRYPTO_RESET <= 1'b0;
			if (wact_r && (widx_r >= dcnt_r))
				wact_r <= 1'b0;
			// A held write is lost if anything but a checksum follows
			if (byte_done && (idx_r == 3'h0) && ack_c && O_WRITE_PENDING &&
				(shreg_r[3:0] != setce_pkg::OP_SYS_WR))
			begin
				O_WRITE_PENDING <= 1'b0; // RL19
				O_CRYPTO_RESET <= 1'b1;
			end
			else if (end_c)
			begin
				unique case (op)
				setce_pkg::OP_WR_USER:
					if (wr_ok_r && (dcnt_r != '0))
					begin
						if (I_CRYPTO_MODE)
							O_WRITE_PENDING <= 1'b1; // RL18
						else
						begin
							wact_r <= 1'b1;
							busy_go_r <= 1'b1;
							busy_len_r <= O_ANTI_TEAR ? BW'(BUSY_AT_CYC) :
								BW'(BUSY_WR_CYC); // RL8
						end
					end
				setce_pkg::OP_SYS_WR:
				begin
					if (a1_r == setce_pkg::SW_ZONE)
						O_ANTI_TEAR <= 1'b0;
					else if (a1_r == setce_pkg::SW_ZONE_AT)
						O_ANTI_TEAR <= 1'b1; // RL16
					else
					begin
						busy_go_r <= 1'b1;
						busy_len_r <= ((a1_r == setce_pkg::SW_CFG_AT) ||
							((a1_r == setce_pkg::SW_CSUM) && O_ANTI_TEAR)) ?
							BW'(BUSY_AT_CYC) : BW'(BUSY_WR_CYC); // RL9 RL10
					end
					if (O_WRITE_PENDING)
					begin
						O_WRITE_PENDING <= 1'b0;
						if ((a1_r == setce_pkg::SW_CSUM) && I_CHECKSUM_VALID)
							wact_r <= 1'b1; // RL18
						else
							O_CRYPTO_RESET <= 1'b1; // RL18
					end
				end
				setce_pkg::OP_VERIFY, setce_pkg::OP_PASSWD:
				begin
					busy_go_r <= 1'b1;
					busy_len_r <= BW'(BUSY_CR_CYC); // RL11
				end
				default:
					busy_go_r <= 1'b0;
				endcase
			end
		end
	end

	// Programming port; bytes go out one per cycle, far inside the busy time
	always_ff @(posedge I_REF_CLK)
	begin
		if (I_SRST)
		begin
			widx_r <= '0;
			O_MEM_WE <= 1'b0;
			O_MEM_WDATA <= 8'h00;
			O_MEM_ADDR <= 16'h0000;
			O_MEM_CFG_SEL <= 1'b0;
		end
		else if (wact_r && (widx_r < dcnt_r))
		begin
			O_MEM_WE <= 1'b1;
			O_MEM_WDATA <= buf_r[widx_r[BI_W-1:0]];
			O_MEM_ADDR <= (wbase_r & ~USER_MASK) |
				((wbase_r + 16'(widx_r)) & USER_MASK);
			O_MEM_CFG_SEL <= 1'b0;
			widx_r <= widx_r + (BI_W + 1)'(1);
		end
		else
		begin
			widx_r <= wact_r ? widx_r : '0;
			O_MEM_WE <= 1'b0;
			O_MEM_ADDR <= ptr_r;
			O_MEM_CFG_SEL <= cfg_sel_r;
		end
	end

	a_poll_withhold: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		byte_done && (idx_r == 3'h0) && busy |=> !O_SDA_OE) // RL4
		else $error("ack given while busy");
	a_univ_addr: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		byte_done && (idx_r == 3'h0) && !busy && (shreg_r[7:4] == 4'hB)
		|=> O_SDA_OE) // RL12
		else $error("universal address not acked");
	a_cfg_addr: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		byte_done && (idx_r == 3'h0) && !busy &&
		(shreg_r[7:4] == device_config_byte_r[3:0]) |=> O_SDA_OE) // RL13
		else $error("configured address not acked");
	a_len_refuse: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		byte_done && (idx_r == 3'h3) && (op == 4'h0) &&
		(!I_WRITE_ALLOWED || (shreg_r > len_max)) |=> !O_SDA_OE) // RL20
		else $error("refused write length acked");
	a_ptr_latch: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		byte_done && (idx_r == 3'h3) |=> ptr_r[7:0] == $past(a2_r)) // RL21
		else $error("pointer not latched");
	a_ptr_wrap: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		tx_load && !cfg_sel_r && ((ptr_r & USER_MASK) == USER_MASK)
		|=> (ptr_r & USER_MASK) == 16'h0000) // RL24
		else $error("pointer did not wrap");
	a_hold_crypto: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		O_WRITE_PENDING |-> !O_MEM_WE) // RL18
		else $error("held write programmed");
	a_busy_bound: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		busy_go_r |-> (busy_len_r <= BW'(BUSY_AT_CYC)) ##1 busy) // RL8 RL9
		else $error("busy time out of bound");
	a_antitear_on: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
		end_c && (op == 4'h4) && (a1_r == 8'h0B) |=> O_ANTI_TEAR [*2]) // RL16
		else $error("anti-tearing not set");
	c_rand_read: cover property (@(posedge I_REF_CLK) disable iff (I_SRST)
		tx_load ##[1:400] tx_load);
	c_crypto_ok: cover property (@(posedge I_REF_CLK) disable iff (I_SRST)
		O_WRITE_PENDING ##[1:1000] O_MEM_WE);
	c_poll_nack: cover property (@(posedge I_REF_CLK) disable iff (I_SRST)
		byte_done && (idx_r == 3'h0) && busy);
endmodule : setce_cmd_engine
`default_nettype wire

// >>> core/setce_pkg.sv
// Shared constants and types of the secure EEPROM command engine
package setce_pkg;
	localparam logic [3:0] UNIV_ADDR = 4'hB;
	localparam logic [7:0] CFG_FACTORY = 8'hFF;
	localparam logic [3:0] OP_WR_USER = 4'h0;
	localparam logic [3:0] OP_RAND_RD = 4'h1;
	localparam logic [3:0] OP_RD_USER = 4'h2;
	localparam logic [3:0] OP_SYS_WR = 4'h4;
	localparam logic [3:0] OP_SYS_RD = 4'h6;
	localparam logic [3:0] OP_VERIFY = 4'h8;
	localparam logic [3:0] OP_PASSWD = 4'hA;
	localparam logic [7:0] SW_CFG = 8'h00;
	localparam logic [7:0] SW_FUSE = 8'h01;
	localparam logic [7:0] SW_CSUM = 8'h02;
	localparam logic [7:0] SW_ZONE = 8'h03;
	localparam logic [7:0] SW_CFG_AT = 8'h08;
	localparam logic [7:0] SW_ZONE_AT = 8'h0B;
	localparam logic [7:0] MAX_LEN = 8'h10;
	localparam logic [7:0] MAX_LEN_AT = 8'h08;
	localparam int CLK_MHZ = 125;
	localparam int T_WR_US = 5000;
	localparam int T_WR_AT_US = 20000;
	localparam int T_CRYPTO_US = 10000;
	localparam int BUSY_WR_CYC = T_WR_US * CLK_MHZ;
	localparam int BUSY_AT_CYC = T_WR_AT_US * CLK_MHZ;
	localparam int BUSY_CR_CYC = T_CRYPTO_US * CLK_MHZ;
	localparam int BUSY_W = 22;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_RACK = 3'b010,
		ST_TX = 3'b011,
		ST_TACK = 3'b100
	} setce_state_t;
endpackage : setce_pkg

// >>> core/setce_twi_sync.sv
// Bus pin synchroniser with clock edge and start/stop detection
`timescale 1ns/1ps
`default_nettype none
module setce_twi_sync (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_scl_rise,
	output logic o_scl_fall,
	output logic o_start,
	output logic o_stop
);
	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic scl_d_r;
	logic sda_d_r;

	// Idle bus level is high on both lines
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			scl_sync_r <= {scl_sync_r[0], i_scl};
			sda_sync_r <= {sda_sync_r[0], i_sda};
			scl_d_r <= scl_sync_r[1];
			sda_d_r <= sda_sync_r[1];
		end
	end

	assign o_sda = sda_sync_r[1];
	assign o_scl_rise = scl_sync_r[1] & ~scl_d_r;
	assign o_scl_fall = ~scl_sync_r[1] & scl_d_r;
	assign o_start = scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
	assign o_stop = scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];
endmodule : setce_twi_sync
`default_nettype wire

// >>> core/setce_busy_timer.sv
// Down counter that holds busy for a loaded number of cycles
`timescale 1ns/1ps
`default_nettype none
module setce_busy_timer #(
	parameter int W = 22
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_load,
	input wire logic [W-1:0] i_count,
	output logic o_busy
);
	logic [W-1:0] cnt_r;

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			cnt_r <= '0;
			o_busy <= 1'b0;
		end
		else if (i_load)
		begin
			cnt_r <= i_count;
			o_busy <= (i_count != '0);
		end
		else if (cnt_r != '0)
		begin
			cnt_r <= cnt_r - W'(1);
			o_busy <= (cnt_r != W'(1));
		end
	end
endmodule : setce_busy_timer
`default_nettype wire

// >>> dv/setce_host_model.sv
// Host controller model that drives the bus clock and data lines
`timescale 1ns/1ps
`default_nettype none
module setce_host_model (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	// Clock rests high between frames; data released means pulled up
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask : tick

	// One bus clock period of 20 reference cycles, data moved mid-low
	task automatic bit_io(input logic tx, output logic rx);
		@(posedge i_clk);
		o_sda <= tx;
		tick(5);
		o_scl <= 1'b1;
		tick(5);
		rx = i_sda;
		tick(5);
		o_scl <= 1'b0;
		tick(4);
	endtask : bit_io

	// Also serves as repeated start in place of a data byte
	task automatic start;
		@(posedge i_clk);
		o_sda <= 1'b1;
		tick(5);
		o_scl <= 1'b1;
		tick(10);
		o_sda <= 1'b0;
		tick(10);
		o_scl <= 1'b0;
		tick(4);
	endtask : start

	task automatic stop;
		@(posedge i_clk);
		o_sda <= 1'b0;
		tick(5);
		o_scl <= 1'b1;
		tick(10);
		o_sda <= 1'b1;
		tick(10);
	endtask : stop

	task automatic xfer(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask : xfer

	task automatic rd(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(nack, r);
	endtask : rd
endmodule : setce_host_model
`default_nettype wire

// >>> dv/test_secure_eeprom_twi_command_engine.sv
// Self-checking bench of the secure EEPROM command engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin \
	errors++; $display("CHECK FAILED %0t %s", $time, m); end end
module test_secure_eeprom_twi_command_engine;
	// Shortened busy counts keep the run short; ratios 2:4:3, not the documented 1:4:2
	localparam int WR_CYC = 600;
	localparam int AT_CYC = 1200;
	localparam int CR_CYC = 900;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] cfg = 8'hFF;
	logic wr_ok = 1'b1;
	logic cry = 1'b0;
	logic cs_ok = 1'b0;
	logic scl, hsda, sda, oe, sout, msel, mwe, busy, at, pend, crst, ack;
	logic [15:0] madr;
	logic [7:0] mwd, mrd, d;
	int errors = 0;
	int tests_run = 0;
	int crst_cnt = 0;
	int blen = 0;
	int k;
	logic [23:0] wr_q[$];
	int busy_q[$];

	always #4 clk = ~clk;
	assign sda = hsda & (oe ? sout : 1'b1);
	assign mrd = madr[7:0] ^ (msel ? 8'hC3 : 8'h3C) ^ {7'h00, madr[8]};

	setce_cmd_engine #(.BUSY_WR_CYC(WR_CYC), .BUSY_AT_CYC(AT_CYC),
		.BUSY_CR_CYC(CR_CYC)) u_dut (.I_REF_CLK(clk), .I_SRST(srst),
		.I_SCL(scl), .I_SDA(sda), .O_SDA_OUT(sout), .O_SDA_OE(oe),
		.I_DEV_CONFIG_BYTE(cfg), .I_WRITE_ALLOWED(wr_ok),
		.I_CRYPTO_MODE(cry), .I_CHECKSUM_VALID(cs_ok), .I_MEM_RDATA(mrd),
		.O_MEM_ADDR(madr), .O_MEM_CFG_SEL(msel), .O_MEM_WE(mwe),
		.O_MEM_WDATA(mwd), .O_BUSY(busy), .O_ANTI_TEAR(at),
		.O_WRITE_PENDING(pend), .O_CRYPTO_RESET(crst));
	setce_host_model u_host (.i_clk(clk), .i_sda(sda), .o_scl(scl),
		.o_sda(hsda));

	function automatic logic [7:0] exp_rd(logic [15:0] p, logic c);
		return p[7:0] ^ (c ? 8'hC3 : 8'h3C) ^ {7'h00, p[8]};
	endfunction : exp_rd

	task automatic end_sim;
		if (errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim

	// Watches programmed bytes, crypto resets and busy length
	always @(posedge clk)
	begin
		if (crst === 1'b1)
			crst_cnt++;
		if (mwe === 1'b1 && msel === 1'b0)
		begin
			if (wr_q.size() == 0)
				`CHK(1'b1, 1'b0, "unexpected write")
			else
				`CHK({madr, mwd}, wr_q.pop_front(), "write byte")
		end
		if (busy === 1'b1)
			blen++;
		else if (blen != 0)
		begin
			if (busy_q.size() == 0)
				`CHK(1'b1, 1'b0, "unexpected busy")
			else
				`CHK(blen, busy_q.pop_front(), "busy length")
			blen = 0;
		end
	end

	task automatic send4(input logic [7:0] c, a1, a2, n, output logic an);
		logic a;
		u_host.start();
		u_host.xfer(c, a);
		`CHK(a, 1'b1, "command ack")
		u_host.xfer(a1, a);
		`CHK(a, 1'b1, "addr1 ack")
		u_host.xfer(a2, a);
		`CHK(a, 1'b1, "addr2 ack")
		u_host.xfer(n, an);
	endtask : send4

	// Bounded polling; the first attempt falls inside the busy time
	task automatic poll(input logic [7:0] c);
		logic a;
		int n;
		a = 1'b0;
		n = 0;
		while (a !== 1'b1 && n < 12)
		begin
			u_host.start();
			u_host.xfer(c, a);
			u_host.stop();
			if (n == 0)
				`CHK(a, 1'b0, "poll while busy")
			n++;
		end
		`CHK(busy, 1'b0, "ack only when ready")
		// A poll that never sees an ack is a hang and must count as a failure
		if (a !== 1'b1)
		begin
			errors++;
			end_sim();
		end
	endtask : poll

	task automatic sys_cmd(input logic [7:0] c, a1, input int len);
		if (len > 0)
			busy_q.push_back(len);
		send4(c, a1, 8'h00, 8'h00, ack);
		u_host.stop();
		if (len > 0)
			poll(8'hB2);
		else
			u_host.tick(8);
	endtask : sys_cmd

	task automatic uwr(input logic [7:0] a2, n, input logic ea, cm);
		logic [7:0] b;
		send4(8'hB0, 8'h01, a2, n, ack);
		`CHK(ack, ea, "length ack")
		for (int i = 0; i < (ea ? n : 0); i++)
		begin
			b = 8'($urandom);
			if (cm)
				wr_q.push_back({8'h01, a2 + 8'(i), b});
			u_host.xfer(b, ack);
		end
		u_host.stop();
	endtask : uwr

	task automatic rrd(input logic [7:0] c, a1, a2, input logic cs,
		input int cnt, input int wrap);
		logic [15:0] p;
		send4(c, a1, a2, 8'h01, ack);
		// Normal user read answers right after its length byte
		if (c == 8'hB2)
			`CHK(ack, 1'b1, "read length ack")
		else
		begin
			u_host.start();
			u_host.xfer(8'hB1, ack);
			`CHK(ack, 1'b1, "read command ack")
		end
		p = {a1, a2};
		for (int i = 0; i < cnt; i++)
		begin
			u_host.rd(i == cnt - 1, d);
			`CHK(d, exp_rd(p, cs), "read byte")
			p = 16'((p + 1) % wrap);
		end
		u_host.stop();
		`CHK(oe, 1'b0, "released after nack")
	endtask : rrd

	initial
	begin
		repeat (90000) @(posedge clk);
		errors++;
		end_sim();
	end

	initial
	begin
		void'($urandom(32'h10A57761));
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		u_host.tick(4);
		// Factory byte first, then a random second address
		for (int j = 0; j < 2; j++)
		begin
			for (int n = 0; n < 16; n++)
			begin
				u_host.start();
				u_host.xfer({4'(n), 4'h2}, ack);
				u_host.stop();
				`CHK(ack, 4'(n) == 4'hB || 4'(n) == cfg[3:0], "match")
			end
			@(posedge clk);
			cfg <= 8'($urandom);
		end
		busy_q.push_back(WR_CYC);
		uwr(8'h00, 8'h10, 1'b1, 1'b1);
		poll(8'hB0);
		uwr(8'h00, 8'h11, 1'b0, 1'b0);
		busy_q.push_back(WR_CYC);
		uwr(8'h05, 8'(1 + $urandom % 11), 1'b1, 1'b1);
		poll(8'hB6);
		sys_cmd(8'hB4, 8'h0B, 0);
		`CHK(at, 1'b1, "anti-tear on")
		uwr(8'h08, 8'h09, 1'b0, 1'b0);
		busy_q.push_back(AT_CYC);
		uwr(8'h08, 8'h08, 1'b1, 1'b1);
		poll(8'hB2);
		sys_cmd(8'hB4, 8'h02, AT_CYC);
		sys_cmd(8'hB4, 8'h03, 0);
		`CHK(at, 1'b0, "anti-tear off")
		sys_cmd(8'hB4, 8'h00, WR_CYC);
		sys_cmd(8'hB4, 8'h01, WR_CYC);
		sys_cmd(8'hB4, 8'h08, AT_CYC);
		sys_cmd(8'hB8, 8'h00, CR_CYC);
		sys_cmd(8'hBA, 8'h10, CR_CYC);
		// Held write commits only behind a valid checksum
		@(posedge clk);
		cry <= 1'b1;
		cs_ok <= 1'b1;
		uwr(8'h20, 8'h02, 1'b1, 1'b1);
		u_host.tick(4);
		`CHK(pend, 1'b1, "write held")
		`CHK(busy, 1'b0, "no busy while held")
		sys_cmd(8'hB4, 8'h02, WR_CYC);
		`CHK(pend, 1'b0, "held write done")
		k = crst_cnt;
		uwr(8'h30, 8'h03, 1'b1, 1'b0);
		@(posedge clk);
		cs_ok <= 1'b0;
		sys_cmd(8'hB4, 8'h02, WR_CYC);
		`CHK(crst_cnt - k, 1, "discard pulse")
		@(posedge clk);
		cry <= 1'b0;
		wr_ok <= 1'b0;
		uwr(8'h40, 8'h04, 1'b0, 1'b0);
		rrd(8'hB0, 8'h01, 8'hFE, 1'b0, 4, 512);
		rrd(8'hB2, 8'h01, 8'hFE, 1'b0, 3, 512);
		@(posedge clk);
		wr_ok <= 1'b1;
		rrd(8'hB4, 8'h00, 8'hFE, 1'b1, 3, 256);
		u_host.tick(10);
		`CHK(wr_q.size() + busy_q.size(), 0, "results left over")
		end_sim();
	end
endmodule : test_secure_eeprom_twi_command_engine
`default_nettype wire
